// [design/scg_pkg.sv]
package scg_pkg;

  // i/o window geometry
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned WIN_LSB    = 3;
  localparam int unsigned NUM_SW     = 8;

  // window bases, one per address switch position (position 1 is index 0)
  localparam logic [NUM_SW-1:0][ADDR_W-1:0] WIN_BASE = '{
    16'h03F8, 16'h0378, 16'h02F8, 16'h0278,
    16'h03B8, 16'h0338, 16'h02B8, 16'h0238
  };

  // byte offsets inside the window
  localparam logic [1:0] OFS_CHAN_A_DATA    = 2'h0;
  localparam logic [1:0] OFS_CHAN_A_CONTROL = 2'h1;
  localparam logic [1:0] OFS_CHAN_B_DATA    = 2'h2;
  localparam logic [1:0] OFS_CHAN_B_CONTROL = 2'h3;
  localparam int unsigned OFS_CHAN_BIT      = 1;
  localparam int unsigned OFS_CTRL_BIT      = 0;

  // index of each interrupt line in the irq output vector
  localparam int unsigned IRQ3_IDX = 0;
  localparam int unsigned IRQ4_IDX = 1;
  localparam int unsigned IRQ5_IDX = 2;

  // index of each dma channel in the dma output vectors
  localparam int unsigned DMA1_IDX = 0;
  localparam int unsigned DMA3_IDX = 1;

  typedef enum logic [1:0] {
    SCG_IRQ_NONE = 2'h0,
    SCG_IRQ_3    = 2'h1,
    SCG_IRQ_4    = 2'h2,
    SCG_IRQ_5    = 2'h3
  } scg_irq_sel_t;

  typedef enum logic [1:0] {
    SCG_DMA_NONE = 2'h0,
    SCG_DMA_CH1  = 2'h1,
    SCG_DMA_CH3  = 2'h2
  } scg_dma_ch_t;

  typedef enum logic [1:0] {
    SCG_DGATE_OFF    = 2'h0,
    SCG_DGATE_ALWAYS = 2'h1,
    SCG_DGATE_CHAN_B_REQUEST_TO_SEND   = 2'h2
  } scg_dma_gate_t;

  typedef enum logic {
    SCG_SPIN_RXC = 1'h0,
    SCG_SPIN_RDB = 1'h1
  } scg_spare_in_t;

  typedef enum logic [1:0] {
    SCG_SPOUT_TXC = 2'h0,
    SCG_SPOUT_DTR = 2'h1,
    SCG_SPOUT_TDB = 2'h2
  } scg_spare_out_t;

  typedef enum logic [2:0] {
    SCG_DMA_IDLE = 3'h1,
    SCG_DMA_REQ  = 3'h2,
    SCG_DMA_XFER = 3'h4
  } scg_dma_state_t;

  // idle level of an undriven serial input (mark)
  localparam logic LINE_IDLE = 1'h1;

endpackage

// [design/scg_dec_if.sv]
interface scg_dec_if;
  logic [scg_pkg::ADDR_W-1:0] addr;
  logic [scg_pkg::NUM_SW-1:0] hit;
  modport host  (output addr, input hit);
  modport match (input addr, output hit);
endinterface

// [design/scg_window_match.sv]
module scg_window_match #(
  parameter int unsigned                IDX  = 0,
  parameter logic [scg_pkg::ADDR_W-1:0] BASE = 16'h0000
) (
  // shared decode bundle
  scg_dec_if.match dec
);

  // address bits 15..3 against the base; low bits pick the port
  assign dec.hit[IDX] = (dec.addr[scg_pkg::ADDR_W-1:scg_pkg::WIN_LSB] == BASE[scg_pkg::ADDR_W-1:scg_pkg::WIN_LSB]);

endmodule

// [design/scg_top.sv]
// Function
// RULE1 - one closed switch selects 8-byte window base
// RULE2 - several closed switches: configuration unsupported
// RULE3 - no switch closed: no address decoded
// RULE4 - offsets 0..3 map A data/control, B data/control
// RULE5 - controller interrupt routed to irq3, 4 or 5
// RULE6 - no interrupt selection drives no line
// RULE7 - RS-485 transmitter follows RTS or stays enabled
// RULE8 - dma request/acknowledge on channel 1, 3, none
// RULE9 - dma drivers always on, follow CHAN_B_REQUEST_TO_SEND, or off
// RULE10 - spare input feeds receive clock or B data
// RULE11 - spare output from txc, dtr or B data
// RULE12 - software raises RTS only while answering polls
// RULE13 - request dma, transfer while acknowledge is returned
// RULE14 - chip select from bits 15..3, pass bits 1..0
// RULE15 - dma only with driver gate and channel selected
module scg_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // board configuration straps
  input  wire logic [scg_pkg::NUM_SW-1:0]    address_switch,
  input  wire scg_pkg::scg_irq_sel_t         irq_route_header,
  input  wire logic                          line_driver_gate_link,
  input  wire scg_pkg::scg_dma_ch_t          dma_channel_header,
  input  wire scg_pkg::scg_dma_gate_t        dma_driver_gate_header,
  input  wire scg_pkg::scg_spare_in_t        spare_in_header,
  input  wire scg_pkg::scg_spare_out_t       spare_pin_header,
  // host i/o bus
  input  wire logic [scg_pkg::ADDR_W-1:0]    host_addr,
  input  wire logic                          host_aen,
  input  wire logic                          host_ior_n,
  input  wire logic                          host_iow_n,
  input  wire logic [1:0]                    host_dack_n,
  // host interrupt and dma lines
  output logic [2:0]                         host_irq,
  output logic [2:0]                         host_irq_oe,
  output logic [1:0]                         host_drq,
  output logic [1:0]                         host_drq_oe,
  // serial controller bus side
  output logic                               sc_cs_n,
  output logic                               sc_rd_n,
  output logic                               sc_wr_n,
  output logic                               sc_chan_b_sel,
  output logic                               sc_ctrl_sel,
  output logic                               sc_dack_n,
  output logic                               config_invalid,
  // serial controller signals
  input  wire logic                          sc_int_n,
  input  wire logic                          sc_dma_req,
  input  wire logic                          sc_rts_a,
  input  wire logic                          chan_b_request_to_send,
  input  wire logic                          sc_dtr_a,
  input  wire logic                          transmit_clock_pin,
  input  wire logic                          chan_b_transmit_line,
  output logic                               receive_clock_pin,
  output logic                               chan_b_receive_line,
  // connector side
  input  wire logic                          spare_in,
  output logic                               spare_out,
  output logic                               rs485_tx_en
);

  scg_dec_if dec ();

  assign dec.addr = host_addr;

  for (genvar i = 0; i < scg_pkg::NUM_SW; i++) begin : g_win
    scg_window_match #(
      .IDX  (i),
      .BASE (scg_pkg::WIN_BASE[i])
    ) u_match (
      .dec (dec)
    );
  end

  logic                          sw_none;
  logic                          sw_onehot;
  logic                          win_hit;
  logic                          io_cycle;
  logic                          dma_gate_open;
  logic                          dma_chan_sel;
  logic                          dack_sel;
  logic                          next_drq;
  scg_pkg::scg_dma_state_t       dma_state;
  scg_pkg::scg_dma_state_t       next_dma_state;

  // one-hot test: a second closed switch makes the board unsupported
  assign sw_none   = (address_switch == '0);  // see RULE3
  assign sw_onehot = !sw_none && ((address_switch & (address_switch - 1'b1)) == '0);  // see RULE2
  // multi-hot is refused outright rather than decoding several windows at once
  assign win_hit   = sw_onehot && ((dec.hit & address_switch) != '0);  // see RULE1
  // aen high means the dma controller owns the address lines
  assign io_cycle  = !host_aen && (!host_ior_n || !host_iow_n);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sc_cs_n        <= 1'b1;
      sc_rd_n        <= 1'b1;
      sc_wr_n        <= 1'b1;
      sc_chan_b_sel  <= 1'b0;
      sc_ctrl_sel    <= 1'b0;
      config_invalid <= 1'b0;
    end else begin
      sc_cs_n        <= !(win_hit && io_cycle);  // see RULE14
      sc_rd_n        <= host_ior_n;
      sc_wr_n        <= host_iow_n;
      sc_chan_b_sel  <= host_addr[scg_pkg::OFS_CHAN_BIT];  // see RULE4
      sc_ctrl_sel    <= host_addr[scg_pkg::OFS_CTRL_BIT];  // see RULE4
      config_invalid <= !sw_none && !sw_onehot;  // see RULE2
    end
  end

  // interrupt routing: the line is only driven when it is the chosen one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_irq    <= '0;
      host_irq_oe <= '0;
    end else begin
      host_irq    <= '0;
      host_irq_oe <= '0;  // see RULE6
      case (irq_route_header)
        scg_pkg::SCG_IRQ_3: begin
          host_irq[scg_pkg::IRQ3_IDX]    <= !sc_int_n;  // see RULE5
          host_irq_oe[scg_pkg::IRQ3_IDX] <= 1'b1;
        end
        scg_pkg::SCG_IRQ_4: begin
          host_irq[scg_pkg::IRQ4_IDX]    <= !sc_int_n;  // see RULE5
          host_irq_oe[scg_pkg::IRQ4_IDX] <= 1'b1;
        end
        scg_pkg::SCG_IRQ_5: begin
          host_irq[scg_pkg::IRQ5_IDX]    <= !sc_int_n;  // see RULE5
          host_irq_oe[scg_pkg::IRQ5_IDX] <= 1'b1;
        end
        default: begin
          host_irq    <= '0;
          host_irq_oe <= '0;
        end
      endcase
    end
  end

  // rs-485 driver: a mis-set link lets an idle node fight the shared line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs485_tx_en <= 1'b0;
    end else begin
      rs485_tx_en <= line_driver_gate_link ? sc_rts_a : 1'b1;  // see RULE7 see RULE12
    end
  end

  // dma driver gate and channel selection
  always_comb begin
    case (dma_driver_gate_header)
      scg_pkg::SCG_DGATE_ALWAYS: dma_gate_open = 1'b1;  // see RULE9
      scg_pkg::SCG_DGATE_CHAN_B_REQUEST_TO_SEND:   dma_gate_open = chan_b_request_to_send;  // see RULE9
      default:                   dma_gate_open = 1'b0;  // see RULE9
    endcase
  end

  always_comb begin
    case (dma_channel_header)
      scg_pkg::SCG_DMA_CH1: begin
        dma_chan_sel = 1'b1;
        dack_sel     = !host_dack_n[scg_pkg::DMA1_IDX];  // see RULE8
      end
      scg_pkg::SCG_DMA_CH3: begin
        dma_chan_sel = 1'b1;
        dack_sel     = !host_dack_n[scg_pkg::DMA3_IDX];  // see RULE8
      end
      default: begin
        dma_chan_sel = 1'b0;
        dack_sel     = 1'b0;
      end
    endcase
  end

  // request, wait for the acknowledge, transfer, then back to idle, or to request if sc_dma_req is still high
  always_comb begin
    next_dma_state = dma_state;
    if (!(dma_gate_open && dma_chan_sel)) begin
      next_dma_state = scg_pkg::SCG_DMA_IDLE;  // see RULE15
    end else begin
      case (dma_state)
        scg_pkg::SCG_DMA_IDLE: begin
          if (sc_dma_req) begin
            next_dma_state = scg_pkg::SCG_DMA_REQ;  // see RULE13
          end
        end
        scg_pkg::SCG_DMA_REQ: begin
          if (dack_sel) begin
            next_dma_state = scg_pkg::SCG_DMA_XFER;  // see RULE13
          end else if (!sc_dma_req) begin
            next_dma_state = scg_pkg::SCG_DMA_IDLE;
          end
        end
        scg_pkg::SCG_DMA_XFER: begin
          if (!dack_sel) begin
            next_dma_state = sc_dma_req ? scg_pkg::SCG_DMA_REQ : scg_pkg::SCG_DMA_IDLE;
          end
        end
        default: next_dma_state = scg_pkg::SCG_DMA_IDLE;
      endcase
    end
  end

  assign next_drq = sc_dma_req && (next_dma_state != scg_pkg::SCG_DMA_IDLE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_state <= scg_pkg::SCG_DMA_IDLE;
    end else begin
      dma_state <= next_dma_state;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_drq    <= '0;
      host_drq_oe <= '0;
      sc_dack_n   <= 1'b1;
    end else begin
      host_drq    <= '0;
      host_drq_oe <= '0;
      // drivers stay tri-stated unless the gate is open and a channel chosen
      if (dma_gate_open) begin  // see RULE15
        case (dma_channel_header)
          scg_pkg::SCG_DMA_CH1: begin
            host_drq[scg_pkg::DMA1_IDX]    <= next_drq;  // see RULE8
            host_drq_oe[scg_pkg::DMA1_IDX] <= 1'b1;
          end
          scg_pkg::SCG_DMA_CH3: begin
            host_drq[scg_pkg::DMA3_IDX]    <= next_drq;  // see RULE8
            host_drq_oe[scg_pkg::DMA3_IDX] <= 1'b1;
          end
          default: begin
            host_drq    <= '0;
            host_drq_oe <= '0;
          end
        endcase
      end
      sc_dack_n <= !(dma_gate_open && dma_chan_sel && dack_sel);  // see RULE13 see RULE15
    end
  end

  // spare connector pins; the unselected controller input rests at mark
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      receive_clock_pin   <= scg_pkg::LINE_IDLE;
      chan_b_receive_line <= scg_pkg::LINE_IDLE;
    end else begin
      receive_clock_pin   <= (spare_in_header == scg_pkg::SCG_SPIN_RXC) ? spare_in : scg_pkg::LINE_IDLE;  // see RULE10
      chan_b_receive_line <= (spare_in_header == scg_pkg::SCG_SPIN_RDB) ? spare_in : scg_pkg::LINE_IDLE;  // see RULE10
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spare_out <= scg_pkg::LINE_IDLE;
    end else begin
      case (spare_pin_header)
        scg_pkg::SCG_SPOUT_TXC: spare_out <= transmit_clock_pin;  // see RULE11
        scg_pkg::SCG_SPOUT_DTR: spare_out <= sc_dtr_a;  // see RULE11
        scg_pkg::SCG_SPOUT_TDB: spare_out <= chan_b_transmit_line;  // see RULE11
        default:                spare_out <= scg_pkg::LINE_IDLE;
      endcase
    end
  end

endmodule

// [sim/scg_checker.sv]
module scg_checker (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   arst_n,
  // straps
  input wire logic [7:0]             address_switch,
  input wire scg_pkg::scg_irq_sel_t  irq_route_header,
  input wire logic                   line_driver_gate_link,
  input wire scg_pkg::scg_dma_ch_t   dma_channel_header,
  input wire scg_pkg::scg_dma_gate_t dma_driver_gate_header,
  // host and controller inputs
  input wire logic [15:0]            host_addr,
  input wire logic                   host_aen,
  input wire logic                   host_ior_n,
  input wire logic                   host_iow_n,
  input wire logic [1:0]             host_dack_n,
  input wire logic                   sc_int_n,
  input wire logic                   sc_dma_req,
  input wire logic                   sc_rts_a,
  input wire logic                   chan_b_request_to_send,
  // outputs
  input wire logic [2:0]             host_irq,
  input wire logic [2:0]             host_irq_oe,
  input wire logic [1:0]             host_drq,
  input wire logic [1:0]             host_drq_oe,
  input wire logic                   sc_cs_n,
  input wire logic                   sc_chan_b_sel,
  input wire logic                   sc_ctrl_sel,
  input wire logic                   sc_dack_n,
  input wire logic                   config_invalid,
  input wire logic                   rs485_tx_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0][15:0] BASE = {16'h03F8, 16'h0378, 16'h02F8, 16'h0278,
                                       16'h03B8, 16'h0338, 16'h02B8, 16'h0238};
  logic hit;
  logic sel;
  logic ok;
  logic idx;
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      hit |= address_switch == (8'h01 << i) && host_addr[15:3] == BASE[i][15:3];
    end
  end
  assign sel = hit && !host_aen && !(host_ior_n && host_iow_n);
  assign idx = dma_channel_header == scg_pkg::SCG_DMA_CH3;
  // gate reading follows the strap, chan_b_request_to_send mode closed while chan_b_request_to_send is low
  assign ok = (dma_channel_header == scg_pkg::SCG_DMA_CH1 || idx) &&
              (dma_driver_gate_header == scg_pkg::SCG_DGATE_ALWAYS ||
               dma_driver_gate_header == scg_pkg::SCG_DGATE_CHAN_B_REQUEST_TO_SEND && chan_b_request_to_send);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_CS_HIT: assert property (sel |=> !sc_cs_n) else $error("no chip select");
  AST_CS_MISS: assert property (!sel |=> sc_cs_n) else $error("stray chip select");
  AST_INVALID: assert property (!$onehot0(address_switch) |=> config_invalid) else $error("no invalid flag");
  AST_SEL: assert property (1'b1 |=> {sc_chan_b_sel, sc_ctrl_sel} == $past(host_addr[1:0]))
    else $error("port select wrong");
  AST_IRQ_NONE: assert property (irq_route_header == scg_pkg::SCG_IRQ_NONE |=> host_irq_oe == 3'h0)
    else $error("irq driven");
  AST_IRQ_SEL: assert property (irq_route_header != scg_pkg::SCG_IRQ_NONE |=>
    host_irq_oe == 3'h1 << ($past(irq_route_header) - 1) && host_irq == ($past(sc_int_n) ? 3'h0 : host_irq_oe))
    else $error("irq route wrong");
  AST_RS485: assert property (1'b1 |=> rs485_tx_en == ($past(line_driver_gate_link) ? $past(sc_rts_a) : 1'b1))
    else $error("tx enable wrong");
  AST_DMA_OFF: assert property (!ok |=> host_drq_oe == 2'h0 && host_drq == 2'h0 && sc_dack_n)
    else $error("dma active while gated");
  AST_DMA_OE: assert property (ok |=> host_drq_oe == 2'h1 << $past(idx)) else $error("dma channel wrong");
  AST_DRQ: assert property (ok && sc_dma_req ##1 ok |-> host_drq == host_drq_oe) else $error("no drq");
  AST_DACK: assert property (ok && !host_dack_n[idx] |=> !sc_dack_n) else $error("no dack");
endmodule

bind scg_top scg_checker u_chk (.*);

// [sim/scg_dma_host.sv]
module scg_dma_host (
  // clock and reset
  input wire logic  clk,
  input wire logic  arst_n,
  // dma lines
  input wire logic [1:0] host_drq,
  input wire logic [3:0] delay,
  output logic [1:0]     host_dack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // grant latency is programmable so the bench can try prompt and slow hosts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      host_dack_n <= 2'h3;
    end else if (host_drq == 2'h0) begin
      cnt <= 4'h0;
      host_dack_n <= 2'h3;
    end else if (cnt < delay) begin
      cnt <= cnt + 4'h1;
    end else begin
      host_dack_n <= ~host_drq;
    end
  end
endmodule

// [sim/serial_card_host_glue_bench.sv]
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module serial_card_host_glue_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BASES [8] = '{16'h0238, 16'h02B8, 16'h0338, 16'h03B8,
                                        16'h0278, 16'h02F8, 16'h0378, 16'h03F8};
  int n_tests = 0;
  int bad_count = 0;
  logic clk = 1'b0, arst_n = 1'b0, line_driver_gate_link = 1'b0, host_aen = 1'b0;
  logic host_ior_n = 1'b1, host_iow_n = 1'b1, sc_int_n = 1'b1, sc_dma_req = 1'b0;
  logic sc_rts_a = 1'b0, chan_b_request_to_send = 1'b0, sc_dtr_a = 1'b0, spare_in = 1'b0;
  logic transmit_clock_pin = 1'b0, chan_b_transmit_line = 1'b0;
  logic [7:0] address_switch = 8'h00;
  logic [15:0] host_addr = 16'h0000;
  logic [3:0] ack_delay = 4'h0;
  scg_pkg::scg_irq_sel_t irq_route_header = scg_pkg::SCG_IRQ_NONE;
  scg_pkg::scg_dma_ch_t dma_channel_header = scg_pkg::SCG_DMA_NONE;
  scg_pkg::scg_dma_gate_t dma_driver_gate_header = scg_pkg::SCG_DGATE_OFF;
  scg_pkg::scg_spare_in_t spare_in_header = scg_pkg::SCG_SPIN_RXC;
  scg_pkg::scg_spare_out_t spare_pin_header = scg_pkg::SCG_SPOUT_TXC;
  logic [2:0] host_irq, host_irq_oe;
  logic [1:0] host_drq, host_drq_oe, host_dack_n;
  logic sc_cs_n, sc_rd_n, sc_wr_n, sc_chan_b_sel, sc_ctrl_sel, sc_dack_n, config_invalid;
  logic receive_clock_pin, chan_b_receive_line, spare_out, rs485_tx_en;

  scg_top u_dut (.*);
  scg_dma_host u_host (.clk(clk), .arst_n(arst_n), .host_drq(host_drq), .delay(ack_delay),
                       .host_dack_n(host_dack_n));

  always #5 clk = ~clk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_decode;
    for (int i = 0; i < 8; i++) begin
      address_switch = 8'h01 << i;
      // back to back accesses, the last one just past the window
      for (int k = 0; k < 5; k++) begin
        host_addr = BASES[i] + (k == 4 ? 16'h0008 : 16'(k));
        host_ior_n = k[0];
        host_iow_n = !k[0];
        tick();
        `CHK(sc_cs_n, k == 4)
        `CHK({sc_chan_b_sel, sc_ctrl_sel, sc_rd_n, sc_wr_n}, {2'(k), k[0], !k[0]})
      end
    end
    host_addr = 16'h03F8;
    host_aen = 1'b1;
    tick();
    `CHK(sc_cs_n, 1'b1)
    host_aen = 1'b0;
    address_switch = 8'h81;
    tick();
    `CHK({sc_cs_n, config_invalid}, 2'h3)
    address_switch = 8'h00;
    tick();
    `CHK({sc_cs_n, config_invalid}, 2'h2)
    host_ior_n = 1'b1;
    host_iow_n = 1'b1;
    $display("decode test done");
  endtask

  task automatic t_irq;
    logic [2:0] exp;
    for (int s = 0; s < 4; s++) begin
      irq_route_header = scg_pkg::scg_irq_sel_t'(s);
      sc_int_n = 1'b0;
      tick();
      exp = s == 0 ? 3'h0 : 3'h1 << (s - 1);
      `CHK({host_irq_oe, host_irq}, {exp, exp})
      sc_int_n = 1'b1;
      tick();
      `CHK(host_irq, 3'h0)
    end
    $display("irq test done");
  endtask

  task automatic t_misc;
    logic [2:0] src;
    for (int k = 0; k < 4; k++) begin
      {line_driver_gate_link, sc_rts_a} = 2'(k);
      tick();
      `CHK(rs485_tx_en, k[1] ? k[0] : 1'b1)
    end
    // both connector levels, so a stuck path cannot pass
    for (int h = 0; h < 4; h++) begin
      spare_in_header = scg_pkg::scg_spare_in_t'(h[1]);
      spare_in = h[0];
      tick();
      `CHK({receive_clock_pin, chan_b_receive_line}, h[1] ? {1'b1, h[0]} : {h[0], 1'b1})
    end
    for (int m = 0; m < 3; m++) begin
      spare_pin_header = scg_pkg::scg_spare_out_t'(m);
      src = 3'h4 >> m;
      for (int v = 0; v < 2; v++) begin
        {transmit_clock_pin, sc_dtr_a, chan_b_transmit_line} = v ? src : ~src;
        tick();
        `CHK(spare_out, v[0])
      end
    end
    // the unused header code parks the pin at mark
    {transmit_clock_pin, sc_dtr_a, chan_b_transmit_line} = 3'h0;
    spare_pin_header = scg_pkg::scg_spare_out_t'(2'h3);
    tick();
    `CHK(spare_out, 1'b1)
    $display("pin test done");
  endtask

  task automatic t_dma;
    int w;
    dma_driver_gate_header = scg_pkg::SCG_DGATE_ALWAYS;
    for (int c = 0; c < 2; c++) begin
      dma_channel_header = c ? scg_pkg::SCG_DMA_CH3 : scg_pkg::SCG_DMA_CH1;
      ack_delay = c ? 4'h3 : 4'h0;
      sc_dma_req = 1'b1;
      tick();
      `CHK({host_drq_oe, host_drq}, {2'h1 << c, 2'h1 << c})
      for (w = 0; w < 20 && sc_dack_n !== 1'b0; w++) begin
        tick();
      end
      if (w == 20) begin
        `CHK(sc_dack_n, 1'b0)
        end_sim();
      end
      sc_dma_req = 1'b0;
      tick(3);
      `CHK({host_drq, sc_dack_n}, 3'h1)
    end
    sc_dma_req = 1'b1;
    for (int g = 0; g < 3; g++) begin
      dma_driver_gate_header = g == 0 ? scg_pkg::SCG_DGATE_OFF : scg_pkg::SCG_DGATE_CHAN_B_REQUEST_TO_SEND;
      chan_b_request_to_send = g == 2;
      tick(2);
      `CHK(host_drq, g == 2 ? 2'h2 : 2'h0)
    end
    dma_channel_header = scg_pkg::SCG_DMA_NONE;
    tick(2);
    `CHK({host_drq_oe, host_drq}, 4'h0)
    sc_dma_req = 1'b0;
    $display("dma test done");
  endtask

  initial begin
    tick(5);
    arst_n = 1'b1;
    tick();
    t_decode();
    t_irq();
    t_misc();
    t_dma();
    end_sim();
  end
endmodule
